// file: phpc_pkg.sv
// Purpose: Constants for the two-wire keyboard/mouse host port
// Assumes: 10 MHz system clock, 16-bit register port
// Notes:   Register offsets are word indices on the plain register port
package phpc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] PHPC_ADDR_DATA   = 2'h0;
	localparam logic [1:0] PHPC_ADDR_CTRL   = 2'h1;
	localparam logic [1:0] PHPC_ADDR_PMU    = 2'h2;
	localparam logic [1:0] PHPC_ADDR_SYSCLK = 2'h3;
	// ----------------------------------------------------------------
	// Control/status field positions
	// ----------------------------------------------------------------
	localparam int PHPC_BIT_RDY    = 0;
	localparam int PHPC_BIT_TXP    = 1;
	localparam int PHPC_BIT_DIS    = 2;
	localparam int PHPC_BIT_IEN    = 3;
	localparam int PHPC_BIT_FIFO   = 4;
	localparam int PHPC_BIT_RX_PARITY_ERROR   = 5;
	localparam int PHPC_BIT_HOLD   = 1;
	localparam int PHPC_BIT_SRST   = 0;
	localparam logic       PHPC_HOLD_RST = 1'h1;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PHPC_CLK_HZ       = 10_000_000;
	localparam int PHPC_INHIBIT_US   = 100;
	localparam int PHPC_INHIBIT_CYC  = PHPC_INHIBIT_US * (PHPC_CLK_HZ / 1_000_000);
	localparam int PHPC_FIFO_DEPTH   = 8;
	localparam int PHPC_FRAME_BITS   = 11;
	typedef enum logic [1:0] {
		PHPC_IDLE    = 2'b00,
		PHPC_INHIBIT = 2'b01,
		PHPC_TXBITS  = 2'b10,
		PHPC_TXACK   = 2'b11
	} phpc_tx_t;
endpackage : phpc_pkg

// file: phpc_port.sv
// Purpose: Host port for a two-wire keyboard/mouse link
// Assumes: Link clock and data are sampled by clk_i through two flops
// Notes:   Open-drain pins: output enable low means pulling the line low
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - Control bit 0 reads 1 while received data waits, else 0.
// - Link transfers happen only while the disable bit is 0.
// - With FIFO-use set, eight 8-bit entries buffer reception; else one byte.
// - Arrival sets ready; without FIFO a data read clears it.
// - With FIFO, ready stays set until the FIFO is empty.
// - Interrupt enable raises the request with the ready flag on reception.
// - A data register read drops the interrupt request.
// - Parity error flag set on a bad byte, zero when parity good.
// - Writing 0 to the disable bit starts sending the loaded byte.
// - Main reset holds the block until power-port bit 1 is written 0.
// - Registers are initialised while main reset is active.
// - Registers are initialised while the soft reset bit is 1.
// - Parity is odd; error flag meaningful only while ready is 1.
// - Transmit-pending reads 1 while a byte is outstanding, else 0.
// - Data register low byte: write transmit byte, read received byte.
module phpc_port
	import phpc_pkg::*;
#(
	parameter int DEPTH = PHPC_FIFO_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [1:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	output logic             link_irq_out_o,
	input  wire logic        link_clk_i,
	output logic             link_clk_oe_o,
	input  wire logic        link_data_i,
	output logic             link_data_oe_o
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic odd_ok(input logic [7:0] d, input logic p);
		odd_ok = ^{d, p};
	endfunction : odd_ok

	// ----------------------------------------------------------------
	// Synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [1:0] clk_s, dat_s, next_clk_s, next_dat_s;
	logic       clk_d, next_clk_d;
	always_comb begin
		next_clk_s = {clk_s[0], link_clk_i};
		next_dat_s = {dat_s[0], link_data_i};
		next_clk_d = clk_s[1];
	end
	// No reset: the pins settle to their idle level long before reset ends
	always_ff @(posedge clk_i) begin
		clk_s <= next_clk_s;
		dat_s <= next_dat_s;
		clk_d <= next_clk_d;
	end
	wire logic fall = clk_d & ~clk_s[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic             hold, srst;
	logic             dis, ien, fuse, rx_parity_error, irq, txp;
	logic [7:0]       txbyte;
	logic [7:0]       mem [DEPTH];
	logic [AW-1:0]    wp, rp;
	logic [AW:0]      cnt;
	logic [10:0]      rsh;
	logic [3:0]       rbits, tbits;
	phpc_tx_t         ts;
	logic [15:0]      tcnt;
	logic [9:0]       tsh;
	logic             coe, doe;
	logic [15:0]      rdata;

	logic             next_hold, next_srst, next_dis, next_ien, next_fuse, next_rx_parity_error, next_irq, next_txp;
	logic [7:0]       next_txbyte;
	logic [AW-1:0]    next_wp, next_rp;
	logic [AW:0]      next_cnt;
	logic [10:0]      next_rsh;
	logic [3:0]       next_rbits, next_tbits;
	phpc_tx_t         next_ts;
	logic [15:0]      next_tcnt;
	logic [9:0]       next_tsh;
	logic             next_coe, next_doe;
	logic [15:0]      next_rdata;
	logic             push, pop, full;

	// ----------------------------------------------------------------
	// Status and next-state logic
	// ----------------------------------------------------------------
	// Held state blocks every register but the power and soft reset bits, the pin synchronisers and the receive memory
	wire logic init = ~nrst_i | hold | srst;
	wire logic rdy  = (cnt != '0);
	assign full = fuse ? (cnt == (AW+1)'(DEPTH)) : (cnt != '0);

	always_comb begin
		next_hold   = hold;
		next_srst   = srst;
		next_dis    = dis;
		next_ien    = ien;
		next_fuse   = fuse;
		next_rx_parity_error   = rx_parity_error;
		next_irq    = irq;
		next_txp    = txp;
		next_txbyte = txbyte;
		next_wp     = wp;
		next_rp     = rp;
		next_cnt    = cnt;
		next_rsh    = rsh;
		next_rbits  = rbits;
		next_ts     = ts;
		next_tcnt   = tcnt;
		next_tsh    = tsh;
		next_tbits  = tbits;
		next_coe    = coe;
		next_doe    = doe;
		next_rdata  = 16'h0000;
		push        = 1'b0;
		pop         = 1'b0;
		// Power and soft reset bits stay writable while the block is held
		if (wr_i && addr_i == PHPC_ADDR_PMU)
			next_hold = wdata_i[PHPC_BIT_HOLD];
		if (wr_i && addr_i == PHPC_ADDR_SYSCLK)
			next_srst = wdata_i[PHPC_BIT_SRST];
		if (rd_i) begin
			case (addr_i)
				PHPC_ADDR_DATA: next_rdata = {8'h00, mem[rp]};
				PHPC_ADDR_CTRL: begin
					next_rdata[PHPC_BIT_RDY]  = rdy;
					next_rdata[PHPC_BIT_TXP]  = txp;
					next_rdata[PHPC_BIT_DIS]  = dis;
					next_rdata[PHPC_BIT_IEN]  = ien;
					next_rdata[PHPC_BIT_FIFO] = fuse;
					next_rdata[PHPC_BIT_RX_PARITY_ERROR] = rx_parity_error & rdy;
				end
				PHPC_ADDR_PMU:    next_rdata[PHPC_BIT_HOLD] = hold;
				PHPC_ADDR_SYSCLK: next_rdata[PHPC_BIT_SRST] = srst;
				default:          next_rdata = 16'h0000;
			endcase
		end
		if (rd_i && addr_i == PHPC_ADDR_DATA && rdy) begin
			pop      = 1'b1;
			next_rp  = rp + 1'b1;
			next_irq = 1'b0;
		end
		if (wr_i && addr_i == PHPC_ADDR_DATA) begin
			next_txbyte = wdata_i[7:0];
			next_txp    = 1'b1;
		end
		if (wr_i && addr_i == PHPC_ADDR_CTRL) begin
			next_dis  = wdata_i[PHPC_BIT_DIS];
			next_ien  = wdata_i[PHPC_BIT_IEN];
			next_fuse = wdata_i[PHPC_BIT_FIFO];
		end
		// Receiver: frames shift in on falling link clock
		if (!dis && ts == PHPC_IDLE && fall) begin
			next_rsh   = {dat_s[1], rsh[10:1]};
			next_rbits = rbits + 1'b1;
			if (rbits == 4'(PHPC_FRAME_BITS - 1)) begin
				next_rbits = 4'h0;
				if (!full) begin
					push      = 1'b1;
					next_rx_parity_error = ~odd_ok(next_rsh[8:1], next_rsh[9]);
					if (ien)
						next_irq = 1'b1;
				end
			end
		end
		if (dis)
			next_rbits = 4'h0;
		// Ring pointers advance in both modes; full caps single mode at one byte
		if (push)
			next_wp = wp + 1'b1;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Transmitter
		case (ts)
			PHPC_IDLE: begin
				if (txp && dis && wr_i && addr_i == PHPC_ADDR_CTRL && !wdata_i[PHPC_BIT_DIS]) begin
					next_ts   = PHPC_INHIBIT;
					next_tcnt = 16'(PHPC_INHIBIT_CYC);
					next_coe  = 1'b0;
				end
			end
			PHPC_INHIBIT: begin
				next_tcnt = tcnt - 16'h0001;
				if (tcnt == 16'h0001) begin
					next_doe   = 1'b0;           // Start bit
					next_coe   = 1'b1;
					next_tsh   = {1'b1, ~^txbyte, txbyte};
					next_tbits = 4'h0;
					next_ts    = PHPC_TXBITS;
				end
			end
			PHPC_TXBITS: begin
				if (fall) begin
					next_tsh   = {1'b1, tsh[9:1]};
					next_doe   = tsh[0];
					next_tbits = tbits + 1'b1;
					if (tbits == 4'h9)
						next_ts = PHPC_TXACK;
				end
			end
			PHPC_TXACK: begin
				next_doe = 1'b1;
				if (fall) begin
					// A byte written in the cycle the ack's falling edge is seen stays pending
					if (!(wr_i && addr_i == PHPC_ADDR_DATA))
						next_txp = 1'b0;
					next_ts  = PHPC_IDLE;
				end
			end
			default: next_ts = PHPC_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!nrst_i || srst)
			hold <= PHPC_HOLD_RST;
		else
			hold <= next_hold;
		if (!nrst_i)
			srst <= 1'b0;
		else
			srst <= next_srst;
		rdata <= init ? 16'h0000 : next_rdata;
		if (init) begin
			dis <= 1'b0; ien <= 1'b0; fuse <= 1'b0; rx_parity_error <= 1'b0;
			irq <= 1'b0; txp <= 1'b0; txbyte <= 8'h00;
			wp <= '0; rp <= '0; cnt <= '0; rsh <= 11'h000; rbits <= 4'h0;
			ts <= PHPC_IDLE; tcnt <= 16'h0000; tsh <= 10'h3FF; tbits <= 4'h0;
			coe <= 1'b1; doe <= 1'b1;
		end else begin
			dis <= next_dis; ien <= next_ien; fuse <= next_fuse; rx_parity_error <= next_rx_parity_error;
			irq <= next_irq; txp <= next_txp; txbyte <= next_txbyte;
			wp <= next_wp; rp <= next_rp; cnt <= next_cnt; rsh <= next_rsh; rbits <= next_rbits;
			ts <= next_ts; tcnt <= next_tcnt; tsh <= next_tsh; tbits <= next_tbits;
			coe <= next_coe; doe <= next_doe;
		end
		if (push)
			mem[wp] <= next_rsh[8:1];
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_o        = rdata;
	assign link_irq_out_o = irq;
	assign link_clk_oe_o  = coe;
	assign link_data_oe_o = doe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_irq_read: assert property (@(posedge clk_i) disable iff (init)
		rd_i && addr_i == PHPC_ADDR_DATA && rdy && !push |=> !link_irq_out_o)
		else $error("irq kept after data read");
	chk_irq_masked: assert property (@(posedge clk_i) disable iff (init)
		!ien && !link_irq_out_o && !(wr_i && addr_i == PHPC_ADDR_CTRL) |=> !link_irq_out_o)
		else $error("irq raised while disabled");
	chk_rx_disabled: assert property (@(posedge clk_i) disable iff (init)
		dis |=> !push) else $error("receive while disabled");
	chk_ready_push: assert property (@(posedge clk_i) disable iff (init)
		push |=> rdy) else $error("ready not set on arrival");
	chk_single_depth: assert property (@(posedge clk_i) disable iff (init)
		!fuse |-> cnt <= 1) else $error("single buffer overfilled");
	chk_fifo_depth: assert property (@(posedge clk_i) disable iff (init)
		cnt <= DEPTH) else $error("fifo overfilled");
	chk_tx_start: assert property (@(posedge clk_i) disable iff (init)
		ts == PHPC_IDLE && txp && dis && wr_i && addr_i == PHPC_ADDR_CTRL && !wdata_i[PHPC_BIT_DIS]
		|=> ts == PHPC_INHIBIT ##1 !link_clk_oe_o) else $error("transmit did not start");
	chk_txp_busy: assert property (@(posedge clk_i) disable iff (init)
		ts != PHPC_IDLE |-> txp) else $error("pending low during send");
	chk_hold_reset: assert property (@(posedge clk_i)
		!nrst_i |=> hold && rdata_o == 16'h0000) else $error("reset not held");

	// Receive side and register reads
	chk_irq_set: assert property (@(posedge clk_i) disable iff (init)
		push && ien |=> link_irq_out_o && rdy)
		else $error("irq not raised with ready");
	chk_ready_clear: assert property (@(posedge clk_i) disable iff (init)
		!fuse && pop && !push |=> !rdy)
		else $error("ready kept after single read");
	chk_fifo_keep: assert property (@(posedge clk_i) disable iff (init)
		fuse && pop && cnt > (AW+1)'(1) |=> rdy)
		else $error("ready dropped with data left");
	chk_fifo_empty: assert property (@(posedge clk_i) disable iff (init)
		fuse && pop && !push && cnt == (AW+1)'(1) |=> !rdy)
		else $error("ready kept on empty fifo");
	chk_ready_read: assert property (@(posedge clk_i) disable iff (init)
		rd_i && addr_i == PHPC_ADDR_CTRL |=> rdata_o[PHPC_BIT_RDY] == $past(rdy))
		else $error("ready bit misreported");
	chk_rx_parity_error_mask: assert property (@(posedge clk_i) disable iff (init)
		rd_i && addr_i == PHPC_ADDR_CTRL && !rdy |=> !rdata_o[PHPC_BIT_RX_PARITY_ERROR])
		else $error("parity error shown without data");
	chk_txp_read: assert property (@(posedge clk_i) disable iff (init)
		rd_i && addr_i == PHPC_ADDR_CTRL |=> rdata_o[PHPC_BIT_TXP] == $past(txp))
		else $error("pending bit misreported");
	chk_rdata_idle: assert property (@(posedge clk_i) disable iff (init)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outlived its cycle");

	// Transmit side
	chk_tx_load: assert property (@(posedge clk_i) disable iff (init)
		wr_i && addr_i == PHPC_ADDR_DATA |=> txp && txbyte == 8'($past(wdata_i)))
		else $error("transmit byte not loaded");
	chk_inhibit_low: assert property (@(posedge clk_i) disable iff (init)
		ts == PHPC_INHIBIT |-> !link_clk_oe_o)
		else $error("clock released during inhibit");
	chk_start_bit: assert property (@(posedge clk_i) disable iff (init)
		ts == PHPC_INHIBIT && tcnt == 16'h0001 |=> ts == PHPC_TXBITS && !link_data_oe_o && link_clk_oe_o)
		else $error("start bit not driven");
	chk_tx_end: assert property (@(posedge clk_i) disable iff (init)
		ts == PHPC_TXACK && fall && !(wr_i && addr_i == PHPC_ADDR_DATA) |=> ts == PHPC_IDLE && !txp)
		else $error("pending kept after send");

	// Cycles spent holding the link clock low before a send
	logic [15:0] inh_seen, next_inh_seen;
	always_comb begin
		next_inh_seen = (ts == PHPC_INHIBIT) ? inh_seen + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk_i) begin
		inh_seen <= init ? 16'h0000 : next_inh_seen;
	end
	chk_inhibit_len: assert property (@(posedge clk_i) disable iff (init)
		ts == PHPC_INHIBIT && next_ts == PHPC_TXBITS |-> inh_seen == 16'(PHPC_INHIBIT_CYC - 1))
		else $error("inhibit length wrong");

	// Reset paths
	chk_main_init: assert property (@(posedge clk_i)
		!nrst_i |=> !link_irq_out_o && link_clk_oe_o && link_data_oe_o && !txp)
		else $error("outputs not initialised by reset");
	chk_soft_init: assert property (@(posedge clk_i)
		srst |=> hold && !link_irq_out_o && link_clk_oe_o && link_data_oe_o && !txp)
		else $error("soft reset did not initialise");
endmodule : phpc_port

// file: phpc_kbd_model.sv
// Purpose: Far-side keyboard model for the host port bench
// Assumes: Open-drain lines with pull-ups, 800 ns link clock period
// Notes:   Link clock stands still between frames
`timescale 1ns/1ps
module phpc_kbd_model (
	input  wire logic clk_line_i,
	input  wire logic dat_line_i,
	output logic      clk_rel_o,
	output logic      dat_rel_o
);
	initial begin
		clk_rel_o = 1'b1;
		dat_rel_o = 1'b1;
	end
	// ----------------------------------------------------------------
	// Frames toward the host
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		f = {1'b1, ~^b ^ bad, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			dat_rel_o = f[i];
			#200 clk_rel_o = 1'b0;
			#400 clk_rel_o = 1'b1;
			#200;
		end
		dat_rel_o = 1'b1;
	endtask : send
	// ----------------------------------------------------------------
	// Frames from the host
	// ----------------------------------------------------------------
	// Sample late in the high phase: host data trails our fall by its sync lag
	task automatic take(output logic [9:0] r, output logic start);
		wait (clk_line_i === 1'b0);
		wait (clk_line_i === 1'b1);
		// Both lines change in one update; let the data line settle first
		#10 start = dat_line_i;
		#390;
		for (int i = 0; i < 10; i++) begin
			clk_rel_o = 1'b0;
			#400 clk_rel_o = 1'b1;
			#390 r[i] = dat_line_i;
			#10;
		end
		dat_rel_o = 1'b0;
		clk_rel_o = 1'b0;
		#400 clk_rel_o = 1'b1;
		#400 dat_rel_o = 1'b1;
	endtask : take
endmodule : phpc_kbd_model

// file: tb_phpc_top.sv
// Purpose: Self-checking bench for the two-wire host port
// Assumes: Register port with one-cycle read latency
// Notes:   Lines are wired-AND of both parties' releases
`timescale 1ns/1ps
module tb_top
	import phpc_pkg::*;
;
	localparam logic [15:0] RDY  = 16'h0001 << PHPC_BIT_RDY;
	localparam logic [15:0] TXP  = 16'h0001 << PHPC_BIT_TXP;
	localparam logic [15:0] DIS  = 16'h0001 << PHPC_BIT_DIS;
	localparam logic [15:0] IEN  = 16'h0001 << PHPC_BIT_IEN;
	localparam logic [15:0] FIFO = 16'h0001 << PHPC_BIT_FIFO;
	localparam logic [15:0] RX_PARITY_ERROR = 16'h0001 << PHPC_BIT_RX_PARITY_ERROR;
	logic        clk_i;
	logic        nrst_i;
	logic [1:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] rdata;
	logic        link_irq;
	logic        clk_oe;
	logic        dat_oe;
	logic        clk_rel;
	logic        dat_rel;
	wire         clk_line = clk_oe & clk_rel;
	wire         dat_line = dat_oe & dat_rel;
	int          n_fail;
	int          samples_checked;
	phpc_port phpc_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .link_irq_out_o(link_irq), .link_clk_i(clk_line),
		.link_clk_oe_o(clk_oe), .link_data_i(dat_line), .link_data_oe_o(dat_oe));
	phpc_kbd_model phpc_kbd_model_inst (.clk_line_i(clk_line), .dat_line_i(dat_line),
		.clk_rel_o(clk_rel), .dat_rel_o(dat_rel));
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic rdc(input logic [15:0] exp);
		logic [15:0] d;
		rd(PHPC_ADDR_CTRL, d);
		chk(d, exp);
	endtask : rdc
	// Upper data bits carry no defined value
	task automatic rdd(input logic [7:0] exp);
		logic [15:0] d;
		rd(PHPC_ADDR_DATA, d);
		chk({8'h00, d[7:0]}, {8'h00, exp});
	endtask : rdd
	task automatic rx(input logic [7:0] b, input logic bad);
		phpc_kbd_model_inst.send(b, bad);
		repeat (10) @(posedge clk_i);
	endtask : rx
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic s_hold();
		chk({13'h0000, link_irq, clk_oe, dat_oe}, 16'h0003);
		wr(PHPC_ADDR_CTRL, IEN);
		rdc(16'h0000);
		wr(PHPC_ADDR_PMU, 16'h0000);
		wr(PHPC_ADDR_CTRL, IEN);
		rdc(IEN);
	endtask : s_hold
	task automatic s_rx();
		rx(8'hA5, 1'b0);
		chk({15'h0000, link_irq}, 16'h0001);
		rdc(IEN | RDY);
		rdd(8'hA5);
		chk({15'h0000, link_irq}, 16'h0000);
		rdc(IEN);
		rx(8'h3C, 1'b1);
		rdc(IEN | RDY | RX_PARITY_ERROR);
		rdd(8'h3C);
		rdc(IEN);
	endtask : s_rx
	task automatic s_fifo();
		wr(PHPC_ADDR_CTRL, FIFO);
		for (int i = 0; i < 9; i++) rx(8'(8'h10 + i), 1'b0);
		chk({15'h0000, link_irq}, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			rdc(FIFO | RDY);
			rdd(8'(8'h10 + i));
		end
		rdc(FIFO);
	endtask : s_fifo
	task automatic s_tx();
		logic [15:0] d;
		logic [9:0]  r;
		logic        s;
		rx(8'h5A, 1'b0);
		wr(PHPC_ADDR_CTRL, DIS);
		rdc(DIS | RDY);
		rx(8'h66, 1'b0);
		rdc(DIS | RDY);
		rdd(8'h5A);
		rdc(DIS);
		wr(PHPC_ADDR_DATA, 16'h003C);
		rdc(DIS | TXP);
		fork
			phpc_kbd_model_inst.take(r, s);
			wr(PHPC_ADDR_CTRL, 16'h0000);
		join
		d = 16'hFFFF;
		for (int i = 0; i < 40 && d[PHPC_BIT_TXP] !== 1'b0; i++) rd(PHPC_ADDR_CTRL, d);
		chk(d, 16'h0000);
		chk({5'h00, s, r}, 16'h033C);
	endtask : s_tx
	task automatic s_srst();
		wr(PHPC_ADDR_CTRL, IEN | FIFO);
		wr(PHPC_ADDR_SYSCLK, 16'h0001);
		rdc(16'h0000);
		wr(PHPC_ADDR_SYSCLK, 16'h0000);
		wr(PHPC_ADDR_CTRL, IEN);
		rdc(16'h0000);
		wr(PHPC_ADDR_PMU, 16'h0000);
		rdc(16'h0000);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		wr(PHPC_ADDR_CTRL, IEN);
		rdc(16'h0000);
		wr(PHPC_ADDR_PMU, 16'h0000);
		rdc(16'h0000);
		wr(PHPC_ADDR_CTRL, IEN);
		rdc(IEN);
	endtask : s_srst
	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		nrst_i  = 1'b0;
		addr_i  = 2'h0;
		wdata_i = 16'h0000;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		s_hold();
		s_rx();
		s_fifo();
		s_tx();
		s_srst();
		report_and_stop();
	end
	// Run needs well under 1 ms; twice that means a hang
	initial begin
		#2_000_000;
		n_fail++;
		report_and_stop();
	end
endmodule : tb_top
